// ===== shared/csd_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface csd_dec_if;
   logic [csd_pkg::ADDR_W-1:0]  addr;
   logic [csd_pkg::NUM_WIN-1:0] win_hit;
   logic [csd_pkg::NUM_SUB-1:0] sub_hit;

   modport dec (
      input  addr,
      output win_hit,
      output sub_hit
   );

   modport user (
      output addr,
      input  win_hit,
      input  sub_hit
   );
endinterface

`default_nettype wire

// ===== shared/csd_pkg.sv
package csd_pkg;

   // Widths of the processor local bus, the wait count and the phase period field
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int WAIT_W = 4;
   localparam int PER_W  = 5;

   // Wait-state programming
   localparam logic [WAIT_W-1:0] WAIT_RESET = 4'hF;
   localparam logic [WAIT_W-1:0] WAIT_MAX   = 4'hF;

   // Bus timing reference against the core clock
   localparam int SYS_CLK_PERIOD_NS  = 100;
   localparam int CORE_CLK_PERIOD_NS = 10;
   localparam int CYCLES_PER_SYS     =
      (SYS_CLK_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

   // Phase lengths in system clock periods
   localparam logic [PER_W-1:0] SETUP_PERIODS = 5'h01;
   localparam logic [PER_W-1:0] HOLD_PERIODS  = 5'h01;
   localparam logic [PER_W-1:0] STROBE_BASE   = 5'h01;

   // Processor-level 256-byte windows, compared on address bits 15..8
   localparam int NUM_WIN     = 7;
   localparam int IDX_USER_A  = 0;
   localparam int IDX_ONBOARD = 1;
   localparam int IDX_USER_B  = 2;
   localparam int IDX_USER_C  = 3;
   localparam int IDX_RESV    = 4;
   localparam int IDX_GP_FIVE = 5;
   localparam int IDX_GP_SIX  = 6;
   localparam logic [7:0] WIN_BASE [NUM_WIN] =
      '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};

   // Sub-selects inside the on-board window, compared on address bits 7..4
   localparam int NUM_SUB   = 7;
   localparam int SUB_CLOCK = 0;
   localparam int SUB_CONVA = 1;
   localparam int SUB_CONVB = 2;
   localparam int SUB_USB   = 3;
   localparam int SUB_DAC   = 4;
   localparam int SUB_CVT   = 5;
   localparam int SUB_FLASH = 6;
   localparam logic [3:0] SUB_LO [NUM_SUB] =
      '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hE};
   localparam logic [3:0] SUB_HI [NUM_SUB] =
      '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hF};

   // Access sequence
   typedef enum logic [1:0] {
      CSD_IDLE,
      CSD_SETUP,
      CSD_STROBE,
      CSD_HOLD
   } csd_state_e;

endpackage

// ===== src/csd_addr_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module csd_addr_decoder #(
   parameter bit GP_SELECTS = 1'b0
) (
   // Address in, hits out
   csd_dec_if.dec bus
);

   function automatic logic win_match(input logic [7:0] page, input logic [7:0] base);
      win_match = (page == base);
   endfunction

   function automatic logic in_range(input logic [3:0] nib,
                                     input logic [3:0] lo,
                                     input logic [3:0] hi);
      in_range = (nib >= lo) && (nib <= hi);
   endfunction

   genvar i;
   generate
      // Full upper byte compared, so anything at or above 0x0700 hits nothing
      for (i = 0; i < csd_pkg::NUM_WIN; i++) begin : g_win
         if (i >= csd_pkg::IDX_GP_FIVE && !GP_SELECTS) begin : g_off
            assign bus.win_hit[i] = 1'b0;
         end else begin : g_on
            assign bus.win_hit[i] = win_match(bus.addr[15:8], csd_pkg::WIN_BASE[i]);
         end
      end
      // Ranges are disjoint, so at most one sub-select can hit
      for (i = 0; i < csd_pkg::NUM_SUB; i++) begin : g_sub
         assign bus.sub_hit[i] =
            win_match(bus.addr[15:8], csd_pkg::WIN_BASE[csd_pkg::IDX_ONBOARD]) &&
            in_range(bus.addr[7:4], csd_pkg::SUB_LO[i], csd_pkg::SUB_HI[i]);
      end
   endgenerate

endmodule

`default_nettype wire

// ===== src/csd_io_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module csd_io_decoder #(
   parameter bit GP_SELECTS = 1'b0,
   parameter int CYCLES_PER_SYS = csd_pkg::CYCLES_PER_SYS
) (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      nrst,
   // Processor I/O request
   input  wire logic                      io_req,
   input  wire logic [csd_pkg::ADDR_W-1:0] io_addr,
   input  wire logic                      io_write,
   input  wire logic                      io_word,
   input  wire logic [csd_pkg::DATA_W-1:0] io_wdata,
   output logic      [csd_pkg::DATA_W-1:0] io_rdata,
   output logic                           io_done,
   output logic                           io_busy,
   output logic                           io_unmapped,
   output logic                           io_misaligned,
   // Wait-state configuration
   input  wire logic [csd_pkg::WAIT_W-1:0] wait_cfg,
   input  wire logic                      wait_cfg_load,
   output logic      [csd_pkg::WAIT_W-1:0] wait_cur,
   // Peripheral bus
   output logic      [csd_pkg::ADDR_W-1:0] per_addr,
   output logic                           per_rd_n,
   output logic                           per_wr_n,
   output logic                           per_lo_en_n,
   output logic                           per_hi_en_n,
   output logic      [csd_pkg::DATA_W-1:0] per_wdata,
   output logic                           per_wdata_oe,
   input  wire logic [csd_pkg::DATA_W-1:0] per_rdata,
   // Processor-level selects
   output logic                           user_sel_a_n,
   output logic                           onboard_group_sel_n,
   output logic                           user_sel_b_n,
   output logic                           user_sel_c_n,
   output logic                           reserved_sel_n,
   output logic                           gp_window_five_n,
   output logic                           gp_window_six_n,
   // On-board sub-selects
   output logic                           clock_sel_n,
   output logic                           conv_a_sel_n,
   output logic                           conv_b_sel_n,
   output logic                           usb_bridge_sel_n,
   output logic                           dac_sel_n,
   output logic                           convert_start_n,
   output logic                           flash_card_sel_n
);

   generate
      if (CYCLES_PER_SYS < 1) begin : g_chk
         $error("csd_io_decoder: CYCLES_PER_SYS must be at least one");
      end
   endgenerate

   localparam int AW = csd_pkg::ADDR_W;
   localparam int DW = csd_pkg::DATA_W;
   localparam int NW = csd_pkg::NUM_WIN;
   localparam int NS = csd_pkg::NUM_SUB;
   // Sized for the longest phase the period input can ask for, not just 16 periods
   localparam int TMR_W = $clog2((2 ** csd_pkg::PER_W) * CYCLES_PER_SYS);

   csd_dec_if dec_bus ();

   // Sequencer state
   csd_pkg::csd_state_e state_d, state_q;
   logic [AW-1:0]       addr_d, addr_q;
   logic                write_d, write_q;
   logic                word_d, word_q;
   logic [DW-1:0]       wdata_d, wdata_q;
   logic [NW-1:0]       win_d, win_q;
   logic [NS-1:0]       sub_d, sub_q;
   logic [csd_pkg::WAIT_W-1:0] wait_d, wait_q;

   // Timer control
   logic                       tmr_start;
   logic [csd_pkg::PER_W-1:0]  tmr_periods;
   logic                       tmr_done;

   // Registered outputs
   logic [DW-1:0] rdata_d, rdata_q;
   logic          done_d, done_q;
   logic          unmapped_d, unmapped_q;
   logic          misal_d, misal_q;
   logic          rd_n_d, rd_n_q;
   logic          wr_n_d, wr_n_q;
   logic          lo_n_d, lo_n_q;
   logic          hi_n_d, hi_n_q;
   logic          oe_d, oe_q;
   logic [DW-1:0] pwdata_d, pwdata_q;
   logic [NW-1:0] win_n_d, win_n_q;
   logic [NS-1:0] sub_n_d, sub_n_q;
   logic          sel_on;
   logic          busy_q;

   // Decoder looks at the live request address so the hit is latched with it
   assign dec_bus.addr = io_addr;

   csd_addr_decoder #(
      .GP_SELECTS (GP_SELECTS)
   ) u_dec (
      .bus (dec_bus)
   );

   csd_wait_timer #(
      .CYCLES_PER_SYS (CYCLES_PER_SYS),
      .CNT_W          (TMR_W)
   ) u_tmr (
      .core_clk (core_clk),
      .nrst     (nrst),
      .start    (tmr_start),
      .periods  (tmr_periods),
      .done     (tmr_done)
   );

   // Wait count; a change mid-access applies from the next strobe phase
   always_comb begin
      wait_d = wait_q;
      if (wait_cfg_load) begin
         wait_d = wait_cfg;
      end
   end

   // Access sequencer
   always_comb begin
      state_d     = state_q;
      addr_d      = addr_q;
      write_d     = write_q;
      word_d      = word_q;
      wdata_d     = wdata_q;
      win_d       = win_q;
      sub_d       = sub_q;
      rdata_d     = rdata_q;
      done_d      = 1'b0;
      unmapped_d  = 1'b0;
      misal_d     = 1'b0;
      tmr_start   = 1'b0;
      tmr_periods = csd_pkg::SETUP_PERIODS;
      unique case (state_q)
         csd_pkg::CSD_IDLE: begin
            // Requests while busy are dropped; io_busy tells the host to wait
            if (io_req) begin
               state_d   = csd_pkg::CSD_SETUP;
               addr_d    = io_addr;
               write_d   = io_write;
               word_d    = io_word;
               wdata_d   = io_wdata;
               win_d     = dec_bus.win_hit;
               sub_d     = dec_bus.sub_hit;
               tmr_start = 1'b1;
            end
         end
         csd_pkg::CSD_SETUP: begin
            if (tmr_done) begin
               state_d     = csd_pkg::CSD_STROBE;
               tmr_start   = 1'b1;
               tmr_periods = csd_pkg::STROBE_BASE + csd_pkg::PER_W'(wait_q);
            end
         end
         csd_pkg::CSD_STROBE: begin
            if (tmr_done) begin
               state_d     = csd_pkg::CSD_HOLD;
               tmr_start   = 1'b1;
               tmr_periods = csd_pkg::HOLD_PERIODS;
               if (!write_q) begin
                  // Odd byte or misaligned word arrives on the high lane and is returned low
                  if (addr_q[0]) begin
                     rdata_d = {8'h00, per_rdata[15:8]};
                  end else if (word_q) begin
                     rdata_d = per_rdata;
                  end else begin
                     rdata_d = {8'h00, per_rdata[7:0]};
                  end
               end
            end
         end
         csd_pkg::CSD_HOLD: begin
            if (tmr_done) begin
               state_d    = csd_pkg::CSD_IDLE;
               done_d     = 1'b1;
               unmapped_d = (win_q == '0);
               misal_d    = word_q && addr_q[0];
            end
         end
      endcase
   end

   // Pin values for the cycle being entered
   always_comb begin
      sel_on   = (state_d != csd_pkg::CSD_IDLE);
      rd_n_d   = !((state_d == csd_pkg::CSD_STROBE) && !write_d);
      wr_n_d   = !((state_d == csd_pkg::CSD_STROBE) && write_d);
      // Misaligned word is served as its high byte only
      lo_n_d   = !(sel_on && !addr_d[0]);
      hi_n_d   = !(sel_on && (word_d || addr_d[0]));
      oe_d     = sel_on && write_d;
      pwdata_d = pwdata_q;
      if (sel_on && write_d) begin
         pwdata_d = addr_d[0] ? {wdata_d[7:0], 8'h00} : wdata_d;
      end
      win_n_d  = ~(win_d & {NW{sel_on}});
      sub_n_d  = ~(sub_d & {NS{sel_on}});
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_q    <= csd_pkg::CSD_IDLE;
         addr_q     <= '0;
         write_q    <= 1'b0;
         word_q     <= 1'b0;
         wdata_q    <= '0;
         win_q      <= '0;
         sub_q      <= '0;
         wait_q     <= csd_pkg::WAIT_RESET;
         rdata_q    <= '0;
         done_q     <= 1'b0;
         unmapped_q <= 1'b0;
         misal_q    <= 1'b0;
         rd_n_q     <= 1'b1;
         wr_n_q     <= 1'b1;
         lo_n_q     <= 1'b1;
         hi_n_q     <= 1'b1;
         oe_q       <= 1'b0;
         pwdata_q   <= '0;
         win_n_q    <= '1;
         sub_n_q    <= '1;
         busy_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         addr_q     <= addr_d;
         write_q    <= write_d;
         word_q     <= word_d;
         wdata_q    <= wdata_d;
         win_q      <= win_d;
         sub_q      <= sub_d;
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
         done_q     <= done_d;
         unmapped_q <= unmapped_d;
         misal_q    <= misal_d;
         rd_n_q     <= rd_n_d;
         wr_n_q     <= wr_n_d;
         lo_n_q     <= lo_n_d;
         hi_n_q     <= hi_n_d;
         oe_q       <= oe_d;
         pwdata_q   <= pwdata_d;
         win_n_q    <= win_n_d;
         sub_n_q    <= sub_n_d;
         busy_q     <= sel_on;
      end
   end

   // Host side
   assign io_rdata      = rdata_q;
   assign io_done       = done_q;
   // Own flop so the pin carries no decode glitch
   assign io_busy       = busy_q;
   assign io_unmapped   = unmapped_q;
   assign io_misaligned = misal_q;
   assign wait_cur      = wait_q;

   // Peripheral side; address stays on the pins after the access ends
   assign per_addr      = addr_q;
   assign per_rd_n      = rd_n_q;
   assign per_wr_n      = wr_n_q;
   assign per_lo_en_n   = lo_n_q;
   assign per_hi_en_n   = hi_n_q;
   assign per_wdata     = pwdata_q;
   assign per_wdata_oe  = oe_q;

   assign user_sel_a_n        = win_n_q[csd_pkg::IDX_USER_A];
   assign onboard_group_sel_n = win_n_q[csd_pkg::IDX_ONBOARD];
   assign user_sel_b_n        = win_n_q[csd_pkg::IDX_USER_B];
   assign user_sel_c_n        = win_n_q[csd_pkg::IDX_USER_C];
   assign reserved_sel_n      = win_n_q[csd_pkg::IDX_RESV];
   assign gp_window_five_n    = win_n_q[csd_pkg::IDX_GP_FIVE];
   assign gp_window_six_n     = win_n_q[csd_pkg::IDX_GP_SIX];

   assign clock_sel_n      = sub_n_q[csd_pkg::SUB_CLOCK];
   assign conv_a_sel_n     = sub_n_q[csd_pkg::SUB_CONVA];
   assign conv_b_sel_n     = sub_n_q[csd_pkg::SUB_CONVB];
   assign usb_bridge_sel_n = sub_n_q[csd_pkg::SUB_USB];
   assign dac_sel_n        = sub_n_q[csd_pkg::SUB_DAC];
   assign convert_start_n  = sub_n_q[csd_pkg::SUB_CVT];
   assign flash_card_sel_n = sub_n_q[csd_pkg::SUB_FLASH];

endmodule

`default_nettype wire

// ===== src/csd_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none

module csd_wait_timer #(
   parameter int CYCLES_PER_SYS = csd_pkg::CYCLES_PER_SYS,
   parameter int CNT_W          = 8
) (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     nrst,
   // Control
   input  wire logic                     start,
   input  wire logic [csd_pkg::PER_W-1:0] periods,
   // Status
   output logic                          done
);

   generate
      if (CYCLES_PER_SYS < 1 || (2 ** csd_pkg::PER_W) * CYCLES_PER_SYS > (2 ** CNT_W)) begin : g_chk
         $error("csd_wait_timer: counter too narrow for the longest phase");
      end
   endgenerate

   logic [CNT_W-1:0] count_d, count_q;
   logic             run_d, run_q;
   logic [CNT_W-1:0] load_val;

   assign load_val = CNT_W'(periods * CYCLES_PER_SYS - 1);
   assign done     = run_q && (count_q == '0);

   always_comb begin
      count_d = count_q;
      run_d   = run_q;
      if (start) begin
         count_d = load_val;
         run_d   = 1'b1;
      end else if (done) begin
         run_d = 1'b0;
      end else if (run_q) begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         count_q <= '0;
         run_q   <= 1'b0;
      end else begin
         count_q <= count_d;
         run_q   <= run_d;
      end
   end

endmodule

`default_nettype wire

// ===== testbench/csd_io_decoder_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module csd_io_decoder_assertions #(
   parameter bit GP_SELECTS     = 1'b0,
   parameter int CYCLES_PER_SYS = 10
) (
   // Clock and reset
   input wire logic                         core_clk,
   input wire logic                         nrst,
   // Request side
   input wire logic                         io_req,
   input wire logic                         io_busy,
   input wire logic                         io_done,
   input wire logic                         io_unmapped,
   input wire logic                         io_misaligned,
   input wire logic [csd_pkg::WAIT_W-1:0]   wait_cfg,
   input wire logic                         wait_cfg_load,
   input wire logic [csd_pkg::WAIT_W-1:0]   wait_cur,
   input wire logic [csd_pkg::ADDR_W-1:0]   per_addr,
   // Selects
   input wire logic                         user_sel_a_n,
   input wire logic                         onboard_group_sel_n,
   input wire logic                         user_sel_b_n,
   input wire logic                         user_sel_c_n,
   input wire logic                         reserved_sel_n,
   input wire logic                         gp_window_five_n,
   input wire logic                         gp_window_six_n,
   input wire logic                         clock_sel_n,
   input wire logic                         conv_a_sel_n,
   input wire logic                         conv_b_sel_n,
   input wire logic                         usb_bridge_sel_n,
   input wire logic                         dac_sel_n,
   input wire logic                         convert_start_n,
   input wire logic                         flash_card_sel_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Cycles since the take, and the wait count that access runs with
   int         cnt_q;
   logic [3:0] w_q;
   always_ff @(posedge core_clk) begin
      if (!nrst) cnt_q <= 0;
      else if (io_req && !io_busy) cnt_q <= 1;
      else if (io_done) cnt_q <= 0;
      else if (cnt_q != 0) cnt_q <= cnt_q + 1;
      if (cnt_q == 1) w_q <= wait_cur;
   end

   onehot_win_a: assert property ($onehot0(~{user_sel_a_n, onboard_group_sel_n,
         user_sel_b_n, user_sel_c_n, reserved_sel_n, gp_window_five_n, gp_window_six_n}))
      else $error("more than one window select");
   onehot_sub_a: assert property ($onehot0(~{clock_sel_n, conv_a_sel_n, conv_b_sel_n,
         usb_bridge_sel_n, dac_sel_n, convert_start_n, flash_card_sel_n}))
      else $error("more than one sub-select");
   sub_in_group_a: assert property (!(&{clock_sel_n, conv_a_sel_n, conv_b_sel_n,
         usb_bridge_sel_n, dac_sel_n, convert_start_n, flash_card_sel_n}) |-> !onboard_group_sel_n)
      else $error("sub-select outside group window");
   user_a_range_a: assert property (!user_sel_a_n |-> per_addr[15:8] == 8'h00)
      else $error("first user select off range");
   group_range_a: assert property (!onboard_group_sel_n |-> per_addr[15:8] == 8'h01)
      else $error("group select off range");
   user_bc_range_a: assert property ((user_sel_b_n || per_addr[15:8] == 8'h02)
         && (user_sel_c_n || per_addr[15:8] == 8'h03))
      else $error("third or fourth select off range");
   gp_quiet_a: assert property (GP_SELECTS || (gp_window_five_n && gp_window_six_n))
      else $error("general purpose window selected");
   edge_subs_a: assert property ((clock_sel_n || per_addr[15:5] == 11'h008)
         && (flash_card_sel_n || per_addr[15:5] == 11'h00F))
      else $error("clock or flash select off range");
   done_time_a: assert property (io_done |-> cnt_q == (w_q + 3) * CYCLES_PER_SYS + 1)
      else $error("access length wrong");
   reset_wait_a: assert property ($rose(nrst) |-> wait_cur == 4'hF)
      else $error("wait count not fifteen after reset");
   wait_load_a: assert property (wait_cfg_load |=> wait_cur == $past(wait_cfg))
      else $error("wait count not loaded");
   flag_pulse_a: assert property ((io_unmapped || io_misaligned) |-> io_done)
      else $error("status flag without done");

   cover property (!flash_card_sel_n);
   cover property (io_unmapped);
   cover property (io_req && io_done);
endmodule

bind csd_io_decoder csd_io_decoder_assertions #(
   .GP_SELECTS     (GP_SELECTS),
   .CYCLES_PER_SYS (CYCLES_PER_SYS)
) u_chk (.*);

`default_nettype wire

// ===== testbench/csd_io_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module csd_io_decoder_tb_top;
   localparam int P = 1;

   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        word;
      logic [3:0]  wt;
      logic [13:0] sel;
      logic [1:0]  unm;
   } csd_row_s;

   logic        core_clk, nrst, io_req, io_write, io_word, wait_cfg_load;
   logic        io_done, io_busy, io_unmapped, io_misaligned, per_rd_n, per_wr_n;
   logic        per_lo_en_n, per_hi_en_n, per_wdata_oe;
   logic        user_sel_a_n, onboard_group_sel_n, user_sel_b_n, user_sel_c_n;
   logic        reserved_sel_n, gp_window_five_n, gp_window_six_n, clock_sel_n;
   logic        conv_a_sel_n, conv_b_sel_n, usb_bridge_sel_n, dac_sel_n;
   logic        convert_start_n, flash_card_sel_n;
   logic [3:0]  wait_cfg, wait_cur;
   logic [15:0] io_addr, io_wdata, io_rdata, per_addr, per_wdata, per_rdata;
   int          n_mismatch = 0;
   int          total_checks = 0;

   // Select bits: windows a..six in 6:0, sub-selects clock..flash in 13:7
   csd_row_s rows [23] = '{
      '{16'h0020, 1'b0, 1'b0, 4'hF, 14'h0001, 2'h0}, '{16'h00FF, 1'b1, 1'b0, 4'h0, 14'h0001, 2'h0},
      '{16'h0100, 1'b0, 1'b1, 4'h0, 14'h0082, 2'h0}, '{16'h011F, 1'b0, 1'b0, 4'h0, 14'h0082, 2'h0},
      '{16'h0120, 1'b1, 1'b1, 4'h7, 14'h0102, 2'h0}, '{16'h012F, 1'b0, 1'b0, 4'h7, 14'h0102, 2'h0},
      '{16'h0130, 1'b0, 1'b0, 4'h7, 14'h0202, 2'h0}, '{16'h0140, 1'b0, 1'b1, 4'h0, 14'h0402, 2'h0},
      '{16'h0150, 1'b1, 1'b0, 4'h0, 14'h0802, 2'h0}, '{16'h0160, 1'b0, 1'b0, 4'h0, 14'h1002, 2'h0},
      '{16'h016F, 1'b0, 1'b0, 4'h0, 14'h1002, 2'h0}, '{16'h0170, 1'b0, 1'b0, 4'h0, 14'h0002, 2'h0},
      '{16'h01E0, 1'b1, 1'b1, 4'h0, 14'h2002, 2'h0}, '{16'h01FF, 1'b0, 1'b0, 4'h0, 14'h2002, 2'h0},
      '{16'h0200, 1'b1, 1'b1, 4'h0, 14'h0004, 2'h0}, '{16'h03FF, 1'b0, 1'b0, 4'h0, 14'h0008, 2'h0},
      '{16'h0302, 1'b0, 1'b1, 4'hF, 14'h0008, 2'h0}, '{16'h0400, 1'b0, 1'b0, 4'h0, 14'h0010, 2'h0},
      '{16'h05FF, 1'b0, 1'b0, 4'h0, 14'h0000, 2'h2}, '{16'h0600, 1'b0, 1'b0, 4'h0, 14'h0000, 2'h2},
      '{16'h0700, 1'b0, 1'b1, 4'h0, 14'h0000, 2'h1}, '{16'hFFFF, 1'b0, 1'b0, 4'h0, 14'h0000, 2'h1},
      '{16'h0121, 1'b0, 1'b1, 4'h0, 14'h0102, 2'h0}};

   csd_io_decoder #(.CYCLES_PER_SYS(P)) u_dut (.*);
   csd_per_model u_per (.*);

   function automatic logic [13:0] sel_vec();
      return ~{flash_card_sel_n, convert_start_n, dac_sel_n, usb_bridge_sel_n, conv_b_sel_n,
               conv_a_sel_n, clock_sel_n, gp_window_six_n, gp_window_five_n, reserved_sel_n,
               user_sel_c_n, user_sel_b_n, onboard_group_sel_n, user_sel_a_n};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report();
      if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // One access, entered just after an edge; returns in its done cycle
   task automatic run(input csd_row_s r, input bit poke);
      int          n;
      logic        odd;
      logic [15:0] wd, d, e, m;
      odd = r.addr[0];
      wd = ~r.addr;
      if (wait_cur !== r.wt) begin
         wait_cfg = r.wt;
         wait_cfg_load = 1'b1;
         @(posedge core_clk);
         #1 wait_cfg_load = 1'b0;
         chk(16'(wait_cur), 16'(r.wt), "wait count");
      end
      io_addr = r.addr;
      io_write = r.wr;
      io_word = r.word;
      io_wdata = wd;
      io_req = 1'b1;
      @(posedge core_clk);
      #1 io_req = 1'b0;
      @(posedge core_clk);
      #1;
      chk(16'(sel_vec()), 16'(r.sel), "selects");
      chk(per_addr, r.addr, "address");
      chk(16'({per_wr_n, per_rd_n}), 16'({!r.wr, r.wr}), "strobe");
      chk(16'({per_hi_en_n, per_lo_en_n, per_wdata_oe}), 16'({!(odd | r.word), odd, r.wr}),
          "lanes");
      m = odd ? 16'hFF00 : (r.word ? 16'hFFFF : 16'h00FF);
      e = odd ? {wd[7:0], 8'h00} : wd;
      if (r.wr) chk(per_wdata & m, e & m, "write data");
      n = 1;
      while (io_done !== 1'b1 && n < 400) begin
         if (poke) io_req = (n == 2);
         if (poke && n == 2) io_addr = 16'h0200;
         @(posedge core_clk);
         #1 n++;
      end
      chk(16'(n), 16'((r.wt + 3) * P), "access length");
      d = {5'h15, r.addr[7:5], r.addr[7:0]};
      e = odd ? {8'h00, d[15:8]} : (r.word ? d : {8'h00, d[7:0]});
      if (!r.wr) chk(io_rdata, e, "read data");
      chk(16'({io_unmapped, io_misaligned}), 16'({|r.unm, r.word & odd}),
          "status");
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // A run of a few hundred cycles; far beyond that means a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      final_report();
   end

   initial begin
      nrst = 1'b0;
      io_req = 1'b0;
      io_addr = 16'h0000;
      io_write = 1'b0;
      io_word = 1'b0;
      io_wdata = 16'h0000;
      wait_cfg = 4'h0;
      wait_cfg_load = 1'b0;
      repeat (16) @(posedge core_clk);
      #1 nrst = 1'b1;
      chk(16'(wait_cur), 16'h000F, "reset wait");
      chk(16'(sel_vec()), 16'h0000, "reset selects");
      chk(per_addr, 16'h0000, "reset address");
      foreach (rows[i]) run(rows[i], 1'b0);
      // Request during an access must be ignored
      run(rows[0], 1'b1);
      @(posedge core_clk);
      #1;
      chk(16'({io_busy, user_sel_b_n}), 16'h0001, "ignored request");
      // Reset in mid-access drops every select and restores the wait count
      io_addr = 16'h0150;
      io_req = 1'b1;
      @(posedge core_clk);
      #1 io_req = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 nrst = 1'b0;
      @(posedge core_clk);
      #1 nrst = 1'b1;
      chk(16'({io_busy, sel_vec()}), 16'h0000, "selects after reset");
      chk(16'(wait_cur), 16'h000F, "wait after reset");
      run(rows[22], 1'b0);
      final_report();
   end
endmodule

`default_nettype wire

// ===== testbench/csd_per_model.sv
`timescale 1ns/1ps
`default_nettype none

module csd_per_model (
   // Peripheral bus
   input wire logic [csd_pkg::ADDR_W-1:0] per_addr,
   input wire logic                       per_rd_n,
   output logic     [csd_pkg::DATA_W-1:0] per_rdata
);
   logic [15:0] last_q = 16'h0000;

   // Device picked by A7..A5 tags its data, so a wrong lane or byte shows
   always_ff @(negedge per_rd_n) last_q <= {5'h15, per_addr[7:5], per_addr[7:0]};

   // Released bus shows the inverse, so a late sample cannot pass by luck
   always_comb begin
      if (!per_rd_n) per_rdata = {5'h15, per_addr[7:5], per_addr[7:0]};
      else per_rdata = ~last_q;
   end
endmodule

`default_nettype wire
